// [core/reg_buffer_mem.sv]
// Buffered and active copies of the configuration registers.
// Assumes the caller keeps every address below the register depth.
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_params.svh"

module reg_buffer_mem (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Buffer write port
    input wire logic wr_en,
    input wire logic [`MEM_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Copy buffer into active registers
    input wire logic update,
    // Serial readback port
    input wire logic [`MEM_AW-1:0] rd_addr,
    input wire logic rd_active,
    output logic [7:0] rd_data,
    // Active register view
    input wire logic [`MEM_AW-1:0] act_addr,
    output logic [7:0] act_data
);

    logic [7:0] buf_mem [0:`REG_DEPTH-1];
    logic [7:0] act_mem [0:`REG_DEPTH-1];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `REG_DEPTH; i++) begin
                buf_mem[i] <= `BYTE_NONE;
            end
        end else if (wr_en) begin
            buf_mem[wr_addr] <= wr_data;
        end
    end

    // All active registers change together
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `REG_DEPTH; i++) begin
                act_mem[i] <= `BYTE_NONE;
            end
        end else if (update) begin
            act_mem <= buf_mem;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= `BYTE_NONE;
            act_data <= `BYTE_NONE;
        end else begin
            rd_data <= rd_active ? act_mem[rd_addr] : buf_mem[rd_addr];
            act_data <= act_mem[act_addr];
        end
    end

endmodule
`default_nettype wire

// [core/spi_control_port_slave.sv]
// Serial peripheral control port: instruction decode, byte transfers,
// stalls and aborts, port configuration and I/O update.
// Assumes pins arrive asynchronous to mclk and that sclk is far slower.
//
// Notes on behaviour
// - Write bits taken on rising sclk, read bits changed on falling sclk.
// - Shared data line is input only in 4-wire, in and out in 3-wire.
// - Separate read output carries read data only in 4-wire mode.
// - Chip select high puts both data outputs in high impedance.
// - After reset: 3-wire and most significant bit first.
// - Chip select falling starts a new communication cycle.
// - Chip select may rise on byte boundaries outside streaming data; port waits keeping its state.
// - Chip select raised after one to seven clocks aborts to idle.
// - Chip select rising off a byte boundary ends transfer, drops partial data.
// - Length code 00/01/10 gives one/two/three bytes, 11 streams.
// - Streaming moves any byte count, address steps, chip select ends it.
// - First sixteen rising edges carry the instruction word.
// - Instruction: read flag, two length bits, 13-bit start address.
// - Writes land in buffer; reserved addresses take a byte slot too.
// - Bit 0 written at 0x05 or the update pin triggers an update.
// - Update copies all buffered registers to active ones together.
// - Read shifts out N bytes from the start address.
// - Readback comes from buffer or active registers.
// - Config bit 6 selects LSB first from the next operation.
// - MSB first: address decrements after each byte.
// - LSB first: address increments after each byte, bits LSB first.
// - Port config register lives in this logic, not the register map.
// - Strap input chooses this port or the two-wire port.
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_params.svh"

module spi_control_port_slave
    import spi_port_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_b,
    output logic read_data_out,
    output logic read_data_out_oe_b,
    // Port select strap and external update pin
    input wire logic port_strap_select,
    input wire logic update_pin,
    // Active register view
    input wire logic [`MEM_AW-1:0] act_addr,
    output logic [7:0] act_data,
    // Port configuration as seen by the chip
    output logic [7:0] serial_port_config
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [15:0] shift_in(input logic [15:0] word,
                                             input logic bit_in,
                                             input logic lsb);
        shift_in = lsb ? {bit_in, word[15:1]} : {word[14:0], bit_in};
    endfunction

    function automatic logic [7:0] byte_of(input logic [15:0] word,
                                           input logic lsb);
        byte_of = lsb ? word[15:8] : word[7:0];
    endfunction

    function automatic logic in_map(input reg_addr_t a);
        in_map = (a <= `LAST_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [2:0] prev;
    logic s_sclk;
    logic s_cs_b;
    logic s_sdio;
    logic s_strap;
    logic s_upd;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 5'h03;
            sync_b <= 5'h03;
            prev <= 3'h2;
        end else begin
            sync_a <= {update_pin, port_strap_select, sdio_in, cs_b, sclk};
            sync_b <= sync_a;
            prev <= {sync_b[4], sync_b[1], sync_b[0]};
        end
    end

    assign s_sclk = sync_b[0];
    assign s_cs_b = sync_b[1];
    assign s_sdio = sync_b[2];
    assign s_strap = sync_b[3];
    assign s_upd = sync_b[4];

    logic spi_on;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic upd_rise;

    assign spi_on = ~s_strap;
    assign sclk_rise = s_sclk & ~prev[0] & ~s_cs_b;
    assign sclk_fall = ~s_sclk & prev[0] & ~s_cs_b;
    assign cs_fall = ~s_cs_b & prev[1];
    assign cs_rise = s_cs_b & ~prev[1];
    assign upd_rise = s_upd & ~prev[2];

    ////////////////////////////////////////////////////////////////////////
    // Transfer strobes

    port_state_t state;
    logic [3:0] bit_cnt;
    logic [15:0] shifter;
    logic [15:0] next_shifter;
    logic cur_lsb;
    logic rw_read;
    logic [1:0] len_code;
    logic [1:0] byte_idx;
    reg_addr_t addr;
    logic streaming;
    logic in_frame;
    logic instr_done;
    logic byte_done;
    logic last_byte;
    logic abort;
    logic [7:0] rx_byte;

    assign next_shifter = shift_in(shifter, s_sdio, cur_lsb);
    assign rx_byte = byte_of(next_shifter, cur_lsb);
    assign streaming = (len_code == `LEN_STREAM);
    assign in_frame = (state != st_idle);
    assign instr_done = (state == st_instr) && sclk_rise &&
                        (bit_cnt == `INSTR_LAST);
    assign byte_done = (state == st_data) && sclk_rise &&
                       (bit_cnt[2:0] == `BYTE_LAST);
    assign last_byte = !streaming && (byte_idx == len_code);
    // Off-boundary rise, or the end of a stream
    assign abort = in_frame && cs_rise &&
                   ((bit_cnt[2:0] != 3'h0) ||
                    ((state == st_data) && streaming));

    ////////////////////////////////////////////////////////////////////////
    // State machine

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= st_idle;
        end else if (!spi_on) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (cs_fall) begin
                        state <= st_instr;
                    end
                end
                st_instr: begin
                    if (abort) begin
                        state <= st_idle;
                    end else if (instr_done) begin
                        state <= st_data;
                    end
                end
                st_data: begin
                    if (abort) begin
                        state <= st_idle;
                    end else if (byte_done && last_byte) begin
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Bit counter; a stall at a byte boundary leaves it untouched
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= 4'h0;
        end else if (!in_frame || abort || instr_done) begin
            bit_cnt <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt <= (state == st_data) ? {1'b0, bit_cnt[2:0] + 3'h1}
                                          : bit_cnt + 4'h1;
        end
    end

    // Shift register; partial data is flushed on abort
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            shifter <= 16'h0000;
        end else if (!in_frame || abort) begin
            shifter <= 16'h0000;
        end else if (sclk_rise) begin
            shifter <= next_shifter;
        end
    end

    // Bit order is fixed for the whole cycle at its start
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur_lsb <= 1'b0;
        end else if ((state == st_idle) && cs_fall) begin
            cur_lsb <= serial_port_config[`CFG_LSB_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction fields and address generator

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rw_read <= 1'b0;
            len_code <= 2'h0;
            addr <= `CFG_ADDR;
            byte_idx <= 2'h0;
        end else if (instr_done) begin
            rw_read <= next_shifter[`RW_BIT];
            len_code <= next_shifter[`LEN_HI:`LEN_LO];
            addr <= next_shifter[`ADDR_HI:0];
            byte_idx <= 2'h0;
        end else if (byte_done) begin
            if (cur_lsb) begin
                addr <= addr + reg_addr_t'(1);
            end else begin
                addr <= addr - reg_addr_t'(1);
            end
            if (!streaming) begin
                byte_idx <= byte_idx + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port configuration register, held here rather than in the map

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            serial_port_config <= `CFG_RESET;
        end else if (byte_done && !rw_read && (addr == `CFG_ADDR)) begin
            serial_port_config <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer writes and I/O update

    logic wr_en;
    logic [7:0] wr_data;
    logic io_update;
    logic [7:0] mem_rdata;

    // Every mapped address except the config address takes its byte, reserved ones included
    assign wr_en = byte_done && !rw_read && in_map(addr) &&
                   (addr != `CFG_ADDR);
    // Update bit clears itself, so it is never stored
    assign wr_data = (addr == `UPD_ADDR) ? (rx_byte & ~`UPD_MASK)
                                         : rx_byte;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            io_update <= 1'b0;
        end else begin
            io_update <= (byte_done && !rw_read && (addr == `UPD_ADDR) &&
                          rx_byte[`UPD_BIT]) || upd_rise;
        end
    end

    reg_buffer_mem u_regs (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(wr_en),
        .wr_addr(addr[`MEM_AW-1:0]),
        .wr_data(wr_data),
        .update(io_update),
        .rd_addr(addr[`MEM_AW-1:0]),
        .rd_active(serial_port_config[`CFG_RB_ACT_BIT]),
        .rd_data(mem_rdata),
        .act_addr(act_addr),
        .act_data(act_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Readback

    logic [7:0] rd_byte;
    logic [2:0] rd_idx;
    logic out_bit;
    logic rd_phase;
    logic four_wire;

    always_comb begin
        if (addr == `CFG_ADDR) begin
            rd_byte = serial_port_config;
        end else if (in_map(addr)) begin
            rd_byte = mem_rdata;
        end else begin
            rd_byte = `BYTE_NONE;
        end
    end

    assign rd_idx = cur_lsb ? bit_cnt[2:0] : (`BYTE_LAST - bit_cnt[2:0]);

    // Next bit goes out on the falling edge for the host's rising edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_bit <= 1'b0;
        end else if ((state == st_data) && rw_read && sclk_fall) begin
            out_bit <= rd_byte[rd_idx];
        end
    end

    // Drive from the first payload falling edge until chip select rises
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_phase <= 1'b0;
        end else if (!spi_on || cs_rise) begin
            rd_phase <= 1'b0;
        end else if ((state == st_data) && rw_read && sclk_fall) begin
            rd_phase <= 1'b1;
        end
    end

    assign four_wire = serial_port_config[`CFG_4WIRE_BIT];
    assign sdio_out = out_bit;
    assign read_data_out = out_bit;
    // Outputs float whenever chip select is high
    assign sdio_oe_b = ~(rd_phase & ~s_cs_b & ~four_wire);
    assign read_data_out_oe_b = ~(rd_phase & ~s_cs_b & four_wire);

endmodule
`default_nettype wire

// [core/spi_port_params.svh]
// Constants of the serial control port: register map, field positions,
// reset values and instruction layout.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

`define ADDR_W 13
`define MEM_AW 6
`define REG_DEPTH 45
`define CFG_ADDR 13'h0000
`define UPD_ADDR 13'h0005
`define LAST_ADDR 13'h002C
`define CFG_RESET 8'h00
`define CFG_LSB_BIT 6
`define CFG_4WIRE_BIT 7
`define CFG_RB_ACT_BIT 5
`define UPD_BIT 0
`define UPD_MASK 8'h01
`define BYTE_NONE 8'h00
`define LEN_STREAM 2'h3
`define INSTR_LAST 4'hF
`define BYTE_LAST 3'h7
`define RW_BIT 15
`define LEN_HI 14
`define LEN_LO 13
`define ADDR_HI 12

`endif

// [core/spi_port_pkg.sv]
// Types shared by the serial control port modules.
// Assumes spi_port_params.svh is on the include path.
`include "spi_port_params.svh"

package spi_port_pkg;

    typedef enum logic [2:0] {
        st_idle  = 3'h1,
        st_instr = 3'h2,
        st_data  = 3'h4
    } port_state_t;

    typedef logic [`ADDR_W-1:0] reg_addr_t;

endpackage

// [tb/spi_control_port_slave_sva.sv]
// Concurrent checks on the serial control port pins and config output.
// Assumes binding to spi_control_port_slave, sclk at least 8 mclk long.
`timescale 1ns/1ns
`default_nettype none

module spi_control_port_slave_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdio_out,
    input wire logic sdio_oe_b,
    input wire logic read_data_out_oe_b,
    input wire logic port_strap_select,
    // Config
    input wire logic [7:0] serial_port_config
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence cs_idle;
        cs_b [*4];
    endsequence
    sequence strap_off;
        port_strap_select [*4];
    endsequence
    a_cs_high_tristate: assert property (cs_idle |-> sdio_oe_b && read_data_out_oe_b)
        else $error("data output driven while deselected");
    a_strap_port_off: assert property (strap_off |-> sdio_oe_b && read_data_out_oe_b)
        else $error("port drives while strap selects other port");
    a_sdo_only_4wire: assert property (!serial_port_config[7] |-> read_data_out_oe_b)
        else $error("separate output driven in 3-wire mode");
    a_sdio_in_4wire: assert property (serial_port_config[7] |-> sdio_oe_b)
        else $error("shared line driven in 4-wire mode");
    a_drive_on_fall: assert property (!sdio_oe_b && $changed(sdio_out) |-> !sclk)
        else $error("read bit changed while serial clock high");
    a_drive_start: assert property ($fell(sdio_oe_b) || $fell(read_data_out_oe_b) |-> !sclk)
        else $error("read drive began outside clock low phase");
    a_cfg_reset_val: assert property ($rose(rst_b) |-> serial_port_config == 8'h00)
        else $error("config not cleared by reset");
    a_cfg_in_frame: assert property ($changed(serial_port_config) |-> !$past(cs_b, 2))
        else $error("config changed outside a selected frame");
endmodule

bind spi_control_port_slave spi_control_port_slave_sva i_sva (.mclk, .rst_b,
    .sclk, .cs_b, .sdio_out, .sdio_oe_b, .read_data_out_oe_b,
    .port_strap_select, .serial_port_config);

`default_nettype wire

// [tb/spi_host_model.sv]
// Serial host model: paces sclk and cs_b from mclk falling edges.
// Assumes the bench sets lsb and four to match the port configuration.
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    // Pacing clock
    input wire logic mclk,
    // Serial pins
    output logic sclk,
    output logic cs_b,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_b,
    input wire logic read_data_out,
    input wire logic read_data_out_oe_b
);
    logic lsb = 1'b0;
    logic four = 1'b0;
    logic drv = 1'b0;
    logic dbit = 1'b0;
    logic junk = 1'b0;
    logic rbit;
    always @(negedge mclk) junk <= ~junk;
    // Undriven line shows a changing pattern, not the last value
    assign sdio_in = !sdio_oe_b ? sdio_out : (drv ? dbit : junk);
    // Undriven separate output reads as the inverse of its last value
    assign rbit = four ? (read_data_out_oe_b ? ~read_data_out : read_data_out)
                       : sdio_in;
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge mclk);
    endtask
    task automatic select(input logic v);
        cs_b = v;
        half();
    endtask
    // Sends n bits of tx and returns the bits sampled on rising sclk
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 0; i < n; i++) begin
            drv = 1'b1;
            dbit = lsb ? tx[i] : tx[7-i];
            half();
            sclk = 1'b1;
            if (lsb)
                rx[i] = rbit;
            else
                rx[7-i] = rbit;
            half();
            sclk = 1'b0;
        end
        drv = 1'b0;
    endtask
endmodule

`default_nettype wire

// [tb/test_spi_control_port_slave.sv]
// Self-checking bench for the serial control port through a host model.
// Assumes spi_port_params.svh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_params.svh"

module test_spi_control_port_slave;
    logic mclk = 1'b0;
    logic rst_b;
    logic port_strap_select;
    logic update_pin;
    logic [`MEM_AW-1:0] act_addr;
    logic sclk, cs_b, sdio_in, sdio_out, sdio_oe_b;
    logic read_data_out, read_data_out_oe_b;
    logic [7:0] act_data, serial_port_config;
    logic [7:0] tx_q [0:3];
    logic [7:0] rx_q [0:3];
    int num_errors = 0;
    int n_tests = 0;

    always #50 mclk = ~mclk;

    spi_control_port_slave i_dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk),
        .cs_b(cs_b), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe_b(sdio_oe_b), .read_data_out(read_data_out),
        .read_data_out_oe_b(read_data_out_oe_b),
        .port_strap_select(port_strap_select), .update_pin(update_pin),
        .act_addr(act_addr), .act_data(act_data),
        .serial_port_config(serial_port_config));
    spi_host_model i_host (.mclk(mclk), .sclk(sclk), .cs_b(cs_b),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b),
        .read_data_out(read_data_out),
        .read_data_out_oe_b(read_data_out_oe_b));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One cycle: instruction word in the current bit order, then nb bytes
    task automatic frame(input logic [15:0] ins, input int nb, input logic st);
        logic [7:0] d;
        int k;
        i_host.select(1'b0);
        i_host.shift(i_host.lsb ? ins[7:0] : ins[15:8], 8, d);
        i_host.shift(i_host.lsb ? ins[15:8] : ins[7:0], 8, d);
        for (k = 0; k < nb; k++) begin
            if (st) begin
                i_host.select(1'b1);
                i_host.select(1'b0);
            end
            i_host.shift(tx_q[k], 8, d);
            rx_q[k] = d;
        end
        i_host.select(1'b1);
    endtask
    task automatic act_check(input logic [5:0] a, input logic [7:0] exp);
        act_addr = a;
        repeat (2) @(negedge mclk);
        check(act_data, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(serial_port_config, 8'h00);
        check({6'h00, sdio_oe_b, read_data_out_oe_b}, 8'h03);
        $display("test reset done");
    endtask
    task automatic t_stall_rw();
        tx_q = '{8'hA1, 8'hB2, 8'hC3, 8'h00};
        frame({1'b0, 2'h2, 13'h000C}, 3, 1'b1);
        tx_q = '{8'h00, 8'h00, 8'h00, 8'h00};
        frame({1'b1, 2'h2, 13'h000C}, 3, 1'b0);
        check(rx_q[0], 8'hA1);
        check(rx_q[1], 8'hB2);
        check(rx_q[2], 8'hC3);
        act_check(6'h0C, 8'h00);
        tx_q[0] = 8'h01;
        frame({1'b0, 2'h0, 13'h0005}, 1, 1'b0);
        act_check(6'h0C, 8'hA1);
        act_check(6'h0A, 8'hC3);
        tx_q[0] = 8'h00;
        frame({1'b1, 2'h0, 13'h0005}, 1, 1'b0);
        check(rx_q[0], 8'h00);
        $display("test stall and update done");
    endtask
    task automatic t_abort();
        logic [7:0] d;
        i_host.select(1'b0);
        i_host.shift(8'h00, 8, d);
        i_host.shift(8'h10, 8, d);
        i_host.shift(8'h5A, 5, d);
        i_host.select(1'b1);
        i_host.select(1'b0);
        i_host.shift(8'h00, 3, d);
        i_host.select(1'b1);
        tx_q[0] = 8'h11;
        frame({1'b0, 2'h0, 13'h000F}, 1, 1'b0);
        tx_q[0] = 8'h00;
        frame({1'b1, 2'h1, 13'h0010}, 2, 1'b0);
        check(rx_q[0], 8'h00);
        check(rx_q[1], 8'h11);
        $display("test abort done");
    endtask
    task automatic t_strap();
        port_strap_select = 1'b1;
        repeat (8) @(negedge mclk);
        tx_q[0] = 8'h5A;
        frame({1'b0, 2'h0, 13'h0012}, 1, 1'b0);
        port_strap_select = 1'b0;
        repeat (8) @(negedge mclk);
        tx_q[0] = 8'h00;
        frame({1'b1, 2'h0, 13'h0012}, 1, 1'b0);
        check(rx_q[0], 8'h00);
        $display("test strap done");
    endtask
    task automatic t_lsb_stream();
        int k;
        tx_q[0] = 8'hC0;
        frame({1'b0, 2'h0, 13'h0000}, 1, 1'b0);
        check(serial_port_config, 8'hC0);
        i_host.lsb = 1'b1;
        i_host.four = 1'b1;
        tx_q = '{8'h11, 8'h22, 8'h33, 8'h44};
        frame({1'b0, 2'h3, 13'h0020}, 4, 1'b0);
        tx_q = '{8'h00, 8'h00, 8'h00, 8'h00};
        frame({1'b1, 2'h3, 13'h0020}, 4, 1'b0);
        for (k = 0; k < 4; k++)
            check(rx_q[k], 8'(8'h11 * (k + 1)));
        update_pin = 1'b1;
        repeat (8) @(negedge mclk);
        update_pin = 1'b0;
        act_check(6'h23, 8'h44);
        tx_q[0] = 8'h99;
        frame({1'b0, 2'h0, 13'h0020}, 1, 1'b0);
        tx_q[0] = 8'hE0;
        frame({1'b0, 2'h0, 13'h0000}, 1, 1'b0);
        check(serial_port_config, 8'hE0);
        tx_q[0] = 8'h00;
        frame({1'b1, 2'h0, 13'h0020}, 1, 1'b0);
        check(rx_q[0], 8'h11);
        $display("test lsb stream done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        port_strap_select = 1'b0;
        update_pin = 1'b0;
        act_addr = 6'h00;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_stall_rw();
        t_abort();
        t_strap();
        t_lsb_stream();
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
